// [rtl/modem_status_scanner.sv]
/*
 * modem_status_scanner: scans the enabled modems of sixteen lines, stops on a status
 * change and reports it in the control/status word; line-status word per line.
 * assumes single-cycle register strobes on the system clock and raw modem pins.
 */
// Behaviour
// - done set on enabled modem status change
// - done halts scan, latches transition bits
// - hold line number, show its status
// - done writable, cleared by init, clear-scan
// - step advances line counter by one
// - step checks new line, ignores done
// - step takes 1.2 us, ones only
// - clear-mux clears all line controls
// - clear-scan clears fields, wipes memory
// - compare fresh samples with scan memory
// - wiped memory shows on inputs as changes
// - bit 12 tracks set-ready, synchronous modems
// - bit 12 tracks secondary receive, asynchronous
// - bit 13 tracks clear-to-send either way
// - bit 14 tracks carrier either way
// - bit 15 only on ring rising
// - transition bits read-only, cleared by init
// - presettable line counter, cleared by init
// - scan cycles; stops within 1.2 us
// - busy while scanning or wiping
// - interrupt enabled done requests level four
`timescale 1ns/100ps
`default_nettype none
module modem_status_scanner
    import modem_scan_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic csr_wr_i,
    input wire logic [15:0] csr_wdata_i,
    output logic [15:0] csr_rdata_o,
    input wire logic lsr_wr_i,
    input wire logic [15:0] lsr_wdata_i,
    output logic [15:0] lsr_rdata_o,
    input wire modem_in_type [NUM_LINES-1:0] modem_i,
    output modem_ctl_type [NUM_LINES-1:0] modem_ctl_o,
    output logic irq_level4_o
);
    // ==================================================================
    // pin synchronisers: three stages, change taken when stages two and three agree
    // ==================================================================
    localparam int PIN_W = 6;
    logic [NUM_LINES-1:0][PIN_W-1:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
    logic [NUM_LINES-1:0][PIN_W-1:0] pin_next;
    always_comb
    begin
        pin_next = pin_reg;
        for (int i = 0; i < NUM_LINES; i++)
        begin
            for (int b = 0; b < PIN_W; b++)
            begin
                if (sync2_reg[i][b] == sync3_reg[i][b])
                    pin_next[i][b] = sync3_reg[i][b];
            end
        end
    end
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            pin_reg <= '0;
        end
        else if (clk_en_i)
        begin
            sync1_reg <= modem_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_reg <= pin_next;
        end
    end

    // ==================================================================
    // per-line present status nibble (ring, carrier, cts, first)
    // ==================================================================
    logic [NUM_LINES-1:0][STAT_W-1:0] live_stat;
    genvar g;
    generate
        for (g = 0; g < NUM_LINES; g++)
        begin : gen_stat
            // pin_reg order: ring, car, cts, dsr, secrx, async
            assign live_stat[g][ST_RING] = pin_reg[g][5];
            assign live_stat[g][ST_CAR] = pin_reg[g][4];
            assign live_stat[g][ST_CTS] = pin_reg[g][3];
            // first bit follows secondary receive for async modems
            assign live_stat[g][ST_DSR] = pin_reg[g][0] ? pin_reg[g][1] : pin_reg[g][2];
        end
    endgenerate

    // ==================================================================
    // registers of the scanner
    // ==================================================================
    scan_state_type state_reg, state_next;
    logic [LINE_W-1:0] line_reg, line_next;          // line counter
    logic scan_en_reg, scan_en_next;
    logic int_en_reg, int_en_next;
    logic done_reg, done_next;
    logic maint_reg, maint_next;                     // held only, no behaviour here
    logic [STAT_W-1:0] trans_reg, trans_next;        // transition field
    logic [CNT_W-1:0] cnt_reg, cnt_next;             // visit and wipe timer
    logic [NUM_LINES-1:0][STAT_W-1:0] mem_reg, mem_next;  // scan memory
    modem_ctl_type [NUM_LINES-1:0] ctl_reg, ctl_next;

    // change found on the selected line, gated by its enable
    logic [STAT_W-1:0] cur, old, diff;
    logic hit;
    logic found;                                     // change taken at the end of this visit
    always_comb
    begin
        cur = live_stat[line_reg];
        old = mem_reg[line_reg];
        diff = cur ^ old;
        // ring only counts off to on
        diff[ST_RING] = cur[ST_RING] & ~old[ST_RING];
        hit = ctl_reg[line_reg].line_enable & (diff != '0);
    end

    // ==================================================================
    // next-state logic for control word, counter, memory and sequencer
    // ==================================================================
    always_comb
    begin
        state_next = state_reg;
        line_next = line_reg;
        scan_en_next = scan_en_reg;
        int_en_next = int_en_reg;
        done_next = done_reg;
        maint_next = maint_reg;
        trans_next = trans_reg;
        cnt_next = cnt_reg;
        mem_next = mem_reg;
        ctl_next = ctl_reg;
        found = 1'b0;
        // per-line controls loaded through the selected line
        if (lsr_wr_i)
        begin
            ctl_next[line_reg].line_enable = lsr_wdata_i[LS_LINE_EN];
            ctl_next[line_reg].terminal_ready = lsr_wdata_i[LS_TERM_RDY];
            ctl_next[line_reg].request_to_send = lsr_wdata_i[LS_RTS];
            ctl_next[line_reg].new_sync = lsr_wdata_i[LS_NEW_SYNC];
        end
        // sequencer
        case (state_reg)
            ST_IDLE:
            begin
                if (scan_en_reg && !done_reg)
                begin
                    state_next = ST_SCAN;
                    cnt_next = CNT_W'(STEP_CYCLES - 1);
                end
            end
            ST_SCAN, ST_STEP:
            begin
                // each visit lasts one step time, so stopping takes at most that
                if (cnt_reg != '0)
                    cnt_next = cnt_reg - 1'b1;
                else
                begin
                    mem_next[line_reg] = cur;           // remember fresh sample
                    if (hit)
                    begin
                        done_next = 1'b1;
                        found = 1'b1;
                        trans_next = diff;
                        state_next = ST_IDLE;           // line stays put
                    end
                    else if (state_reg == ST_SCAN && scan_en_reg && !done_reg)
                    begin
                        line_next = line_reg + 1'b1;    // advance around the lines
                        cnt_next = CNT_W'(STEP_CYCLES - 1);
                    end
                    else
                        state_next = ST_IDLE;
                end
            end
            ST_WIPE:
            begin
                // memory zeroed, so any on input later looks like a rising change
                mem_next = '0;
                if (cnt_reg != '0)
                    cnt_next = cnt_reg - 1'b1;
                else
                    state_next = ST_IDLE;
            end
            default:
                state_next = ST_IDLE;
        endcase
        // host write of the control word
        if (csr_wr_i)
        begin
            line_next = csr_wdata_i[CS_LINE_LO +: LINE_W];      // preset
            scan_en_next = csr_wdata_i[CS_SCAN_EN];
            int_en_next = csr_wdata_i[CS_INT_EN];
            // a change found in the same cycle wins over the written done bit; only a clear scan in the same write drops it
            done_next = csr_wdata_i[CS_DONE] | found;
            maint_next = csr_wdata_i[CS_MAINT];
            // step ignores done; the step visit checks the new line
            if (csr_wdata_i[CS_STEP] && state_reg != ST_WIPE)
            begin
                line_next = line_reg + 1'b1;
                state_next = ST_STEP;
                cnt_next = CNT_W'(STEP_CYCLES - 1);
            end
            if (csr_wdata_i[CS_CLR_MUX])
                ctl_next = '0;
            if (csr_wdata_i[CS_CLR_SCAN])
            begin
                line_next = '0;
                scan_en_next = 1'b0;
                int_en_next = 1'b0;
                done_next = 1'b0;
                maint_next = 1'b0;
                trans_next = '0;
                mem_next = '0;
                state_next = ST_WIPE;
                cnt_next = CNT_W'(WIPE_CYCLES - 1);
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= ST_IDLE;
            line_reg <= '0;
            scan_en_reg <= 1'b0;
            int_en_reg <= 1'b0;
            done_reg <= 1'b0;
            maint_reg <= 1'b0;
            trans_reg <= '0;
            cnt_reg <= '0;
            mem_reg <= '0;
            ctl_reg <= '0;
        end
        else if (clk_en_i)
        begin
            state_reg <= state_next;
            line_reg <= line_next;
            scan_en_reg <= scan_en_next;
            int_en_reg <= int_en_next;
            done_reg <= done_next;
            maint_reg <= maint_next;
            trans_reg <= trans_next;
            cnt_reg <= cnt_next;
            mem_reg <= mem_next;
            ctl_reg <= ctl_next;
        end
    end

    // ==================================================================
    // read data and outputs
    // ==================================================================
    logic busy;
    always_comb
    begin
        busy = (state_reg != ST_IDLE);
        csr_rdata_o = RESET_WORD;
        csr_rdata_o[CS_LINE_LO +: LINE_W] = line_reg;
        csr_rdata_o[CS_BUSY] = busy;
        csr_rdata_o[CS_SCAN_EN] = scan_en_reg;
        csr_rdata_o[CS_INT_EN] = int_en_reg;
        csr_rdata_o[CS_DONE] = done_reg;
        csr_rdata_o[CS_MAINT] = maint_reg;
        // command bits always read zero
        csr_rdata_o[CS_TRANS_LO +: STAT_W] = trans_reg;
        lsr_rdata_o = RESET_WORD;
        lsr_rdata_o[LS_LINE_EN] = ctl_reg[line_reg].line_enable;
        lsr_rdata_o[LS_TERM_RDY] = ctl_reg[line_reg].terminal_ready;
        lsr_rdata_o[LS_RTS] = ctl_reg[line_reg].request_to_send;
        lsr_rdata_o[LS_NEW_SYNC] = ctl_reg[line_reg].new_sync;
        // present levels of the selected enabled modem
        lsr_rdata_o[LS_STAT_LO +: STAT_W] = ctl_reg[line_reg].line_enable ? cur : '0;
    end
    assign modem_ctl_o = ctl_reg;
    assign irq_level4_o = done_reg & int_en_reg;

    // ==================================================================
    // checks
    // ==================================================================
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    chk_irq_follows_done: assert property (irq_level4_o == (done_reg && int_en_reg)) else $error("irq mismatch");
    chk_done_halts_scan: assert property ($rose(done_reg) && !$past(csr_wr_i) |-> state_reg == ST_IDLE) else $error("scan not halted");
    chk_clr_scan_fields: assert property (clk_en_i && csr_wr_i && csr_wdata_i[CS_CLR_SCAN] |=> line_reg == '0 && !done_reg && trans_reg == '0 && state_reg == ST_WIPE) else $error("clear scan incomplete");
    chk_clr_mux_all: assert property (clk_en_i && csr_wr_i && csr_wdata_i[CS_CLR_MUX] |=> ctl_reg == '0) else $error("clear mux incomplete");
    chk_step_advance: assert property (clk_en_i && csr_wr_i && csr_wdata_i[CS_STEP] && !csr_wdata_i[CS_CLR_SCAN] && state_reg != ST_WIPE |=> line_reg == $past(line_reg) + 1'b1 && state_reg == ST_STEP) else $error("step wrong");
    chk_busy_scan: assert property (busy == (state_reg != ST_IDLE) && csr_rdata_o[CS_BUSY] == busy) else $error("busy wrong");
    chk_cmd_read_zero: assert property (!csr_rdata_o[CS_STEP] && !csr_rdata_o[CS_CLR_MUX] && !csr_rdata_o[CS_CLR_SCAN]) else $error("command bit reads one");
    chk_ring_fall_quiet: assert property ((state_reg == ST_SCAN || state_reg == ST_STEP) && cnt_reg == '0 && !csr_wr_i && clk_en_i && !cur[ST_RING] |=> !$rose(trans_reg[ST_RING])) else $error("ring fall flagged");
    chk_disabled_quiet: assert property ((state_reg == ST_SCAN || state_reg == ST_STEP) && cnt_reg == '0 && !csr_wr_i && clk_en_i && !ctl_reg[line_reg].line_enable |=> !$rose(done_reg) && $stable(trans_reg)) else $error("disabled line hit");
    cov_scan_hit: cover property (state_reg == ST_SCAN ##1 $rose(done_reg));
    cov_step_hit: cover property (state_reg == ST_STEP ##1 $rose(done_reg));
    cov_wipe_done: cover property (state_reg == ST_WIPE ##1 state_reg == ST_IDLE);
endmodule : modem_status_scanner
`default_nettype wire

// [shared/modem_scan_pkg.sv]
/*
 * modem_scan_pkg: control/status word layout, line-status layout, timing counts
 * and shared types of the modem status scanner.
 * assumes a 125 MHz system clock.
 */
package modem_scan_pkg;
    // ==================================================================
    // clock and timing
    // ==================================================================
    localparam int CLK_PERIOD_PS = 8000;
    localparam int STEP_TIME_PS = 1200000;      // one line visit, 1.2 us
    localparam int WIPE_TIME_PS = 18800000;     // whole scan memory wipe, 18.8 us
    localparam int STEP_CYCLES = STEP_TIME_PS / CLK_PERIOD_PS;
    localparam int WIPE_CYCLES = WIPE_TIME_PS / CLK_PERIOD_PS;
    localparam int CNT_W = 12;
    // ==================================================================
    // geometry
    // ==================================================================
    localparam int NUM_LINES = 16;
    localparam int LINE_W = 4;
    localparam int STAT_W = 4;
    // ==================================================================
    // control/status word bit positions
    // ==================================================================
    localparam int CS_LINE_LO = 0;
    localparam int CS_BUSY = 4;
    localparam int CS_SCAN_EN = 5;
    localparam int CS_INT_EN = 6;
    localparam int CS_DONE = 7;
    localparam int CS_STEP = 8;
    localparam int CS_MAINT = 9;
    localparam int CS_CLR_MUX = 10;
    localparam int CS_CLR_SCAN = 11;
    localparam int CS_TRANS_LO = 12;
    // ==================================================================
    // status nibble positions (line-status bits 4..7 order)
    // ==================================================================
    localparam int ST_DSR = 0;
    localparam int ST_CTS = 1;
    localparam int ST_CAR = 2;
    localparam int ST_RING = 3;
    // line-status word control bit positions
    localparam int LS_LINE_EN = 0;
    localparam int LS_TERM_RDY = 1;
    localparam int LS_RTS = 2;
    localparam int LS_NEW_SYNC = 3;
    localparam int LS_STAT_LO = 4;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // per-line modem inputs
    typedef struct packed {
        logic ring;
        logic carrier_detect;
        logic clear_to_send;
        logic data_set_ready;
        logic secondary_receive;
        logic async_mode;
    } modem_in_type;

    // per-line modem control outputs
    typedef struct packed {
        logic new_sync;
        logic request_to_send;
        logic terminal_ready;
        logic line_enable;
    } modem_ctl_type;

    // scanner states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SCAN = 4'b0010,
        ST_STEP = 4'b0100,
        ST_WIPE = 4'b1000
    } scan_state_type;
endpackage : modem_scan_pkg

// [tb/modem_bank_model.sv]
/*
 * modem_bank_model: sixteen modems at the far side of the scanner, each holding
 * the status levels last loaded into it by the bench.
 * assumes the bench loads one line at a time, on the system clock.
 */
`timescale 1ns/100ps
`default_nettype none
module modem_bank_model
    import modem_scan_pkg::*;
(
    input wire logic clock_i,
    input wire logic load_i,
    input wire logic [3:0] line_i,
    input wire modem_in_type value_i,
    output modem_in_type [NUM_LINES-1:0] modem_o
);
    // ==================================================================
    // status levels per line
    // ==================================================================
    // all modems start idle, every status line off
    modem_in_type [NUM_LINES-1:0] level_reg = '0;

    // levels move only at the clock; real pins are slower still
    always @(posedge clock_i)
    begin
        if (load_i)
        begin
            level_reg[line_i] <= value_i;
        end
    end

    assign modem_o = level_reg;
endmodule : modem_bank_model
`default_nettype wire

// [tb/modem_status_scanner_bench.sv]
/*
 * modem_status_scanner_bench: self-checking bench for the modem status scanner.
 * assumes the modem bank model at the far side and a free-running 125 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
module modem_status_scanner_bench
    import modem_scan_pkg::*;
;
    // ==================================================================
    // signals
    // ==================================================================
    typedef struct packed {
        logic [3:0] stat;   // ring, carrier, cts, dsr or secondary receive
        logic async;        // asynchronous modem
        logic [3:0] trans;  // transition bits expected; they stay until the next change or a clear scan
        logic done;         // done expected after the step
    } row_type;
    // a ring falling is no change, so done stays low and the old transition bits remain
    localparam row_type ROWS [7] = '{'{4'h1, 1'b0, 4'h1, 1'b1}, '{4'h2, 1'b0, 4'h3, 1'b1},
        '{4'h4, 1'b0, 4'h6, 1'b1}, '{4'h8, 1'b0, 4'hc, 1'b1}, '{4'h0, 1'b0, 4'hc, 1'b0},
        '{4'h1, 1'b1, 4'h1, 1'b1}, '{4'h0, 1'b1, 4'h1, 1'b1}};
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en = 1'b1;
    logic csr_wr = 1'b0;
    logic lsr_wr = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] csr_rdata;
    logic [15:0] lsr_rdata;
    logic irq;
    logic load = 1'b0;
    logic [3:0] load_line = 4'h0;
    modem_in_type load_val = '0;
    modem_in_type [NUM_LINES-1:0] modem_in;
    modem_ctl_type [NUM_LINES-1:0] modem_ctl;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;

    // ==================================================================
    // design and far side
    // ==================================================================
    modem_status_scanner modem_status_scanner_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en), .csr_wr_i(csr_wr), .csr_wdata_i(wdata), .csr_rdata_o(csr_rdata),
        .lsr_wr_i(lsr_wr), .lsr_wdata_i(wdata), .lsr_rdata_o(lsr_rdata),
        .modem_i(modem_in), .modem_ctl_o(modem_ctl), .irq_level4_o(irq));
    modem_bank_model modem_bank_model_inst (.clock_i(clock_i), .load_i(load),
        .line_i(load_line), .value_i(load_val), .modem_o(modem_in));

    // ==================================================================
    // clock and watchdog
    // ==================================================================
    initial
    begin
        forever
        begin
            #4 clock_i = ~clock_i;
        end
    end

    // the whole run needs about 7000 cycles; a hang ends it as a mismatch
    initial
    begin
        forever
        begin
            @(posedge clock_i);
            cycles++;
            if (cycles == 30000)
            begin
                err_count++;
                $display("[ERR] watchdog expected end seen hang");
                finish_test();
            end
        end
    end

    // ==================================================================
    // tasks
    // ==================================================================
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // one-cycle strobe to the control/status word or the line-status word
    task automatic bus_write(input logic to_lsr, input logic [15:0] d);
        @(posedge clock_i);
        #1;
        csr_wr = ~to_lsr;
        lsr_wr = to_lsr;
        wdata = d;
        @(posedge clock_i);
        #1;
        csr_wr = 1'b0;
        lsr_wr = 1'b0;
    endtask : bus_write

    task automatic load_modem(input logic [3:0] line, input logic [3:0] st, input logic async);
        @(posedge clock_i);
        #1;
        load = 1'b1;
        load_line = line;
        load_val = '{st[3], st[2], st[1], st[0] & ~async, st[0] & async, async};
        @(posedge clock_i);
        #1;
        load = 1'b0;
        // leave room for the input synchronisers
        repeat (10) @(posedge clock_i);
    endtask : load_modem

    // bounded wait for the scanner to drop busy, or for the interrupt
    task automatic wait_for(input logic want_irq);
        int n;
        n = 0;
        while ((want_irq ? irq !== 1'b1 : csr_rdata[CS_BUSY] !== 1'b0) && n < 3000)
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        @(posedge clock_i);
        #1;
        // a wait that runs out is a hang: count it and end the run
        if (n >= 3000)
        begin
            err_count++;
            $display("[ERR] wait_for expected idle or irq seen timeout");
            finish_test();
        end
    endtask : wait_for

    task automatic test_end(input string name);
        $display("test %s finished, mismatches so far %0d", name, err_count);
    endtask : test_end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // ==================================================================
    // main sequence
    // ==================================================================
    initial
    begin
        repeat (3) @(posedge clock_i);
        #1;
        sys_rst_i = 1'b0;
        check("csr reset", 16'h0000, csr_rdata);
        check("lsr reset", 16'h0000, lsr_rdata);
        bus_write(1'b0, 16'h0800);
        wait_for(1'b0);
        bus_write(1'b0, 16'h0003);
        bus_write(1'b1, 16'h000f);
        check("line 3 controls", 16'h000f, {12'h000, modem_ctl[3]});
        test_end("reset");
        // one step onto line 3 per row, after the modem levels moved
        foreach (ROWS[i])
        begin
            load_modem(4'h3, ROWS[i].stat, ROWS[i].async);
            bus_write(1'b0, 16'h0002);
            bus_write(1'b0, 16'h0100);
            wait_for(1'b0);
            check("step csr", {ROWS[i].trans, 4'h0, ROWS[i].done, 7'h03}, csr_rdata);
            check("step csr", {ROWS[i].trans, 4'h0, ROWS[i].done, 7'h03}, csr_rdata);
            check("step lsr", {8'h00, ROWS[i].stat, 4'hf}, lsr_rdata);
            test_end("row");
        end
        // a change on a line that was never enabled stays silent
        load_modem(4'h5, 4'h1, 1'b0);
        bus_write(1'b0, 16'h0004);
        bus_write(1'b0, 16'h0100);
        wait_for(1'b0);
        check("disabled csr", 16'h1005, csr_rdata);
        check("disabled lsr", 16'h0000, lsr_rdata);
        test_end("disabled line");
        // done written high must not block a step
        load_modem(4'h3, 4'h2, 1'b0);
        bus_write(1'b0, 16'h0082);
        check("done written", 16'h1082, csr_rdata);
        bus_write(1'b0, 16'h0180);
        wait_for(1'b0);
        check("step under done", 16'h2083, csr_rdata);
        check("irq masked", 16'h0000, {15'h0000, irq});
        // maintenance bit rides along: it reads back, and clear scan must drop it
        bus_write(1'b0, 16'h06c3);
        check("clear mux csr", 16'h22c3, csr_rdata);
        check("irq level", 16'h0001, {15'h0000, irq});
        check("controls cleared", 16'h0000, {15'h0000, |modem_ctl});
        test_end("done and clear mux");
        // wiped memory turns every on status into a fresh change
        bus_write(1'b1, 16'h0001);
        bus_write(1'b0, 16'h0800);
        check("wipe busy", 16'h0010, csr_rdata);
        wait_for(1'b0);
        check("wipe done", 16'h0000, csr_rdata);
        bus_write(1'b0, 16'h0060);
        // the sequencer leaves idle one edge after scan enable lands
        @(posedge clock_i);
        #1;
        check("scanning busy", 16'h0010, csr_rdata & 16'h0010);
        wait_for(1'b1);
        check("scan hit", 16'h20e3, csr_rdata);
        test_end("clear scan");
        // a low clock enable freezes the scanner, host writes included
        clk_en = 1'b0;
        bus_write(1'b0, 16'h0005);
        check("frozen csr", 16'h20e3, csr_rdata);
        clk_en = 1'b1;
        test_end("clock enable");
        // reset in mid-run clears everything at once; the first write after it lands
        sys_rst_i = 1'b1;
        @(posedge clock_i);
        #1;
        check("mid reset csr", 16'h0000, csr_rdata);
        check("mid reset irq", 16'h0000, {15'h0000, irq});
        check("mid reset controls", 16'h0000, {15'h0000, |modem_ctl});
        sys_rst_i = 1'b0;
        bus_write(1'b0, 16'h0007);
        check("write after reset", 16'h0007, csr_rdata);
        test_end("mid-run reset");
        finish_test();
    end
endmodule : modem_status_scanner_bench
`default_nettype wire
